// file: logic/scd_top.sv
// Two-wire control port with command byte decoder, register loads and status read.
//
// Function
// - Write address, command and two address bytes, then repeated start and read data.
// - Read bytes continue while the master acknowledges; a not-acknowledge ends sending.
// - Bus address is 10000 followed by the high then low select pin levels.
// - Last bit of the first byte is direction; zero writes, one reads.
// - Command byte is the first byte after a write address byte.
// - Bit 7 power, bit 6 select, bits 5..3 function, bits 2..0 load code.
// - Select bit chooses analog path or digital storage, decoded with function bits.
// - Codes 0,5,2,7,C,9,A give stop, play, record, cue, read, write, erase.
// - The nine other select and function codes are no-operations.
// - Load codes 1,2,3,5 load address, config 0, 1, 2; others do nothing.
// - A load may accompany any operation, including stop for configuration only.
// - Two bytes after the command fill the selected register, high byte first.
// - Device holds the clock line low until it is ready for more.
// - Write address then read without command returns status, address high, address low with bits 4..0 cleared.
`timescale 1ns/1ps
`include "scd_defines.svh"
module scd_top
	import scd_pkg::*;
#(
	parameter logic [2:0] DEVICE_ID = 3'h5  // Arbitrary value.
)
(
	// Clock and reset.
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	// Bus pins, open drain.
	input  wire logic        SCL_I,
	output logic             SCL_O,
	output logic             SCL_OE_N,
	input  wire logic        SDA_I,
	output logic             SDA_O,
	output logic             SDA_OE_N,
	// Address select straps.
	input  wire logic        ADDR_SELECT_HI_PIN,
	input  wire logic        ADDR_SELECT_LO_PIN,
	// Device core state.
	input  wire logic        DEV_READY,
	input  wire logic [4:0]  DEV_STATUS,
	input  wire logic [15:0] CUR_ADDR,
	// Decoded commands.
	output logic             CMD_STB,
	output scd_op_t          CMD_OP,
	output logic             POWER_UP,
	// Register loads.
	output logic             REG_WR,
	output scd_reg_t         REG_SEL,
	output logic [15:0]      REG_DATA,
	// Digital data stream.
	output logic             WR_STB,
	output logic [7:0]       WR_DATA,
	output logic             RD_REQ,
	input  wire logic [7:0]  RD_DATA
);

	scd_edge_t e;
	scd_regs_t q;
	scd_regs_t d;
	logic      hit;
	logic [7:0] txb;

	scd_bus_edges u_edges (
		.clk     (CLK),
		.sys_rst (SYS_RST),
		.scl_i   (SCL_I),
		.sda_i   (SDA_I),
		.edge_o  (e)
	);

	// Select and function bits map to one operation; unused codes fall to no-op.
	function automatic scd_op_t decode_op(input logic [3:0] fn);
		case (fn)
			`SCD_FN_STOP:   decode_op = SCD_OP_STOP;
			`SCD_FN_PLAY:   decode_op = SCD_OP_PLAY;
			`SCD_FN_RECORD: decode_op = SCD_OP_RECORD;
			`SCD_FN_CUE:    decode_op = SCD_OP_CUE;
			`SCD_FN_DREAD:  decode_op = SCD_OP_DREAD;
			`SCD_FN_DWRITE: decode_op = SCD_OP_DWRITE;
			`SCD_FN_ERASE:  decode_op = SCD_OP_ERASE;
			default:        decode_op = SCD_OP_NOP;
		endcase
	endfunction

	// Load code gives a valid flag and the target register.
	function automatic logic [2:0] decode_reg(input logic [2:0] rg);
		case (rg)
			`SCD_RG_ADDR: decode_reg = {1'b1, SCD_REG_ADDR};
			`SCD_RG_CONFIG_REG_0: decode_reg = {1'b1, SCD_REG_CONFIG_REG_0};
			`SCD_RG_CONFIG_REG_1: decode_reg = {1'b1, SCD_REG_CONFIG_REG_1};
			`SCD_RG_CONFIG_REG_2: decode_reg = {1'b1, SCD_REG_CONFIG_REG_2};
			default:      decode_reg = 3'h0;
		endcase
	endfunction

	// Address compare against the fixed prefix and the two straps.
	assign hit = (q.shift[7:3] == `SCD_ADDR_PREFIX) &&
	             (q.shift[2:1] == {ADDR_SELECT_HI_PIN, ADDR_SELECT_LO_PIN});

	// Byte sequencer; start and stop override whatever the state machine chose.
	always_comb begin
		d = q;
		txb = `SCD_IDLE_BYTE;
		d.cmd_stb = 1'b0;
		d.reg_wr = 1'b0;
		d.wr_stb = 1'b0;
		d.rd_req = 1'b0;
		case (q.st)
			SCD_S_IDLE: begin
				d.st = SCD_S_IDLE;
			end
			SCD_S_RX: begin
				if (e.scl_rise) begin
					d.shift = {q.shift[6:0], e.sda};
					d.cnt = q.cnt + 4'h1;
				end else if (e.scl_fall && q.cnt == `SCD_BITS_PER_BYTE) begin
					d.cnt = 4'h0;
					d.st = SCD_S_ACK;
					d.sda_low = 1'b1;
					d.tx_next = 1'b0;
					if (q.is_addr) begin
						d.is_addr = 1'b0;
						if (!hit) begin
							// Stay off the bus until the next start.
							d.st = SCD_S_IDLE;
							d.sda_low = 1'b0;
						end else if (q.shift[0]) begin
							d.tx_next = 1'b1;
							d.sidx = 2'h0;
						end else begin
							d.status = 1'b1;
							d.stage = 2'h0;
						end
					end else begin
						case (q.stage)
							2'h0: begin
								d.cmd = q.shift;
								d.pwr = q.shift[`SCD_C_POWER];
								d.status = 1'b0;
								d.op = decode_op(q.shift[`SCD_C_FUNC_HI:`SCD_C_FUNC_LO]);
								d.reg_sel = scd_reg_t'(decode_reg(q.shift[`SCD_C_REG_HI:`SCD_C_REG_LO]));
								if (decode_reg(q.shift[`SCD_C_REG_HI:`SCD_C_REG_LO]) != 3'h0) begin
									d.stage = 2'h1;
								end else begin
									d.cmd_stb = 1'b1;
									d.stage = 2'h3;
								end
							end
							2'h1: begin
								d.hi = q.shift;
								d.stage = 2'h2;
							end
							2'h2: begin
								// The operation starts only once its start address is in place.
								d.reg_wr = 1'b1;
								d.reg_data = {q.hi, q.shift};
								d.cmd_stb = 1'b1;
								d.stage = 2'h3;
							end
							default: begin
								if (q.op == SCD_OP_DWRITE) begin
									d.wr_stb = 1'b1;
									d.wr_data = q.shift;
								end
							end
						endcase
					end
				end
			end
			SCD_S_ACK: begin
				if (e.scl_fall) begin
					d.sda_low = 1'b0;
					d.scl_low = 1'b1;
					d.st = SCD_S_HOLD;
				end
			end
			SCD_S_HOLD: begin
				if (DEV_READY) begin
					d.scl_low = 1'b0;
					if (q.tx_next) begin
						if (q.status) begin
							case (q.sidx)
								2'h0:    txb = {DEV_STATUS, DEVICE_ID};
								2'h1:    txb = CUR_ADDR[15:8];
								2'h2:    txb = CUR_ADDR[7:0] & `SCD_BLOCK_MASK;
								default: txb = `SCD_IDLE_BYTE;
							endcase
							if (q.sidx != 2'h3) begin
								d.sidx = q.sidx + 2'h1;
							end
						end else begin
							txb = RD_DATA;
							d.rd_req = 1'b1;
						end
						d.shift = txb;
						d.sda_low = ~txb[7];
						d.st = SCD_S_TX;
					end else begin
						d.st = SCD_S_RX;
					end
				end
			end
			SCD_S_TX: begin
				if (e.scl_fall) begin
					if (q.cnt == `SCD_LAST_TX_BIT) begin
						d.cnt = 4'h0;
						d.sda_low = 1'b0;
						d.st = SCD_S_TXACK;
					end else begin
						d.cnt = q.cnt + 4'h1;
						d.shift = {q.shift[6:0], 1'b1};
						d.sda_low = ~q.shift[6];
					end
				end
			end
			SCD_S_TXACK: begin
				if (e.scl_rise && e.sda) begin
					d.st = SCD_S_IDLE;
				end else if (e.scl_fall) begin
					d.scl_low = 1'b1;
					d.st = SCD_S_HOLD;
				end
			end
			default: begin
				d.st = SCD_S_IDLE;
			end
		endcase
		// A stop ends any transfer and forgets a pending status read.
		if (e.stop) begin
			d.st = SCD_S_IDLE;
			d.sda_low = 1'b0;
			d.scl_low = 1'b0;
			d.status = 1'b0;
		end
		// A start, repeated or not, always restarts address reception.
		if (e.start) begin
			d.st = SCD_S_RX;
			d.is_addr = 1'b1;
			d.cnt = 4'h0;
			d.sda_low = 1'b0;
			d.scl_low = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			q <= '{st: SCD_S_IDLE, op: SCD_OP_NOP, reg_sel: SCD_REG_ADDR, cmd: `SCD_CMD_RST, default: '0};
		end else begin
			q <= d;
		end
	end

	// Open-drain pins only ever pull low.
	assign SCL_O    = 1'b0;
	assign SDA_O    = 1'b0;
	assign SCL_OE_N = ~q.scl_low;
	assign SDA_OE_N = ~q.sda_low;
	assign CMD_STB  = q.cmd_stb;
	assign CMD_OP   = q.op;
	assign POWER_UP = q.pwr;
	assign REG_WR   = q.reg_wr;
	assign REG_SEL  = q.reg_sel;
	assign REG_DATA = q.reg_data;
	assign WR_STB   = q.wr_stb;
	assign WR_DATA  = q.wr_data;
	assign RD_REQ   = q.rd_req;

	// Checks on the sequencer.
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	a_ack_own_addr: assert property ((q.st == SCD_S_ACK && !SDA_OE_N && $past(q.is_addr)) |->
		(q.shift[7:3] == `SCD_ADDR_PREFIX && q.shift[2:1] == {ADDR_SELECT_HI_PIN, ADDR_SELECT_LO_PIN}))
		else $error("acknowledged a foreign address");
	a_dir_read_tx: assert property ((q.st == SCD_S_RX && q.is_addr && e.scl_fall && q.cnt == 4'h8 && hit &&
		q.shift[0] && !e.start && !e.stop) |=> q.tx_next)
		else $error("read direction did not arm transmit");
	a_cmd_power: assert property ($rose(q.stage == 2'h1 || q.stage == 2'h3) && !q.is_addr |->
		POWER_UP == q.cmd[7])
		else $error("power bit not taken from command");
	a_op_decode: assert property (CMD_STB |-> CMD_OP == decode_op(q.cmd[6:3]))
		else $error("operation decode mismatch");
	a_reg_decode: assert property (REG_WR |-> ({1'b1, REG_SEL} == decode_reg(q.cmd[2:0]) && CMD_STB))
		else $error("register load decode mismatch");
	a_load_order: assert property (REG_WR |-> REG_DATA[15:8] == q.hi)
		else $error("high byte not loaded first");
	a_stretch_hold: assert property ((q.st == SCD_S_HOLD && !DEV_READY) |=> !SCL_OE_N)
		else $error("clock released while not ready");
	a_nack_ends: assert property ((q.st == SCD_S_TXACK && e.scl_rise && e.sda && !e.start) |=>
		(q.st == SCD_S_IDLE && SDA_OE_N) [*2])
		else $error("transmit continued after not-acknowledge");
	a_status_no_fetch: assert property ((q.st == SCD_S_HOLD && q.tx_next && q.status) |=> !RD_REQ)
		else $error("status read fetched array data");
	a_read_fetch: assert property ((q.st == SCD_S_HOLD && q.tx_next && !q.status && DEV_READY &&
		!e.start && !e.stop) |=> RD_REQ ##1 !RD_REQ)
		else $error("digital read byte not fetched once");

	c_status_read: cover property (q.st == SCD_S_TX && q.status && q.sidx == 2'h3);
	c_addr_read: cover property (REG_WR && REG_SEL == SCD_REG_ADDR ##[1:1000] RD_REQ);
	c_cfg_only: cover property (REG_WR && REG_SEL == SCD_REG_CONFIG_REG_2 && CMD_OP == SCD_OP_STOP);
	c_stream_write: cover property (WR_STB ##[1:1000] WR_STB);

endmodule

// file: logic/scd_defines.svh
// Constants for the serial command decoder: address, command fields and encodings.
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH

// Fixed upper five bits of the 7-bit bus address.
`define SCD_ADDR_PREFIX   5'h10

// Command byte field positions.
`define SCD_C_POWER       7
`define SCD_C_FUNC_HI     6
`define SCD_C_FUNC_LO     3
`define SCD_C_REG_HI      2
`define SCD_C_REG_LO      0

// Select plus function codes, command bits 6 down to 3.
`define SCD_FN_STOP       4'h0
`define SCD_FN_PLAY       4'h5
`define SCD_FN_RECORD     4'h2
`define SCD_FN_CUE        4'h7
`define SCD_FN_DREAD      4'hC
`define SCD_FN_DWRITE     4'h9
`define SCD_FN_ERASE      4'hA

// Register-load codes, command bits 2 down to 0.
`define SCD_RG_NONE       3'h0
`define SCD_RG_ADDR       3'h1
`define SCD_RG_CONFIG_REG_0       3'h2
`define SCD_RG_CONFIG_REG_1       3'h3
`define SCD_RG_CONFIG_REG_2       3'h5

// Reset values, read-back constants and bit counts.
`define SCD_CMD_RST       8'h00
`define SCD_BLOCK_MASK    8'hE0
`define SCD_IDLE_BYTE     8'hFF
`define SCD_BITS_PER_BYTE 4'h8
`define SCD_LAST_TX_BIT   4'h7

`endif

// file: logic/scd_pkg.sv
// Types shared by the serial command decoder modules.
package scd_pkg;

	typedef enum logic [2:0] {
		SCD_S_IDLE  = 3'h0,
		SCD_S_RX    = 3'h1,
		SCD_S_ACK   = 3'h2,
		SCD_S_HOLD  = 3'h3,
		SCD_S_TX    = 3'h4,
		SCD_S_TXACK = 3'h5
	} scd_state_t;

	typedef enum logic [2:0] {
		SCD_OP_STOP   = 3'h0,
		SCD_OP_PLAY   = 3'h1,
		SCD_OP_RECORD = 3'h2,
		SCD_OP_CUE    = 3'h3,
		SCD_OP_DREAD  = 3'h4,
		SCD_OP_DWRITE = 3'h5,
		SCD_OP_ERASE  = 3'h6,
		SCD_OP_NOP    = 3'h7
	} scd_op_t;

	typedef enum logic [1:0] {
		SCD_REG_ADDR = 2'h0,
		SCD_REG_CONFIG_REG_0 = 2'h1,
		SCD_REG_CONFIG_REG_1 = 2'h2,
		SCD_REG_CONFIG_REG_2 = 2'h3
	} scd_reg_t;

	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic sda;
	} scd_edge_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} scd_line_t;

	typedef struct packed {
		scd_state_t  st;
		logic [3:0]  cnt;
		logic [7:0]  shift;
		logic        is_addr;
		logic        tx_next;
		logic        status;
		logic [1:0]  sidx;
		logic [1:0]  stage;
		logic [7:0]  cmd;
		logic [7:0]  hi;
		logic        sda_low;
		logic        scl_low;
		logic        cmd_stb;
		scd_op_t     op;
		logic        pwr;
		logic        reg_wr;
		scd_reg_t    reg_sel;
		logic [15:0] reg_data;
		logic        wr_stb;
		logic [7:0]  wr_data;
		logic        rd_req;
	} scd_regs_t;

endpackage

// file: logic/scd_bus_edges.sv
// Line sampler that turns the two bus wires into edge, start and stop pulses.
`timescale 1ns/1ps
module scd_bus_edges
	import scd_pkg::*;
(
	// Clock and reset.
	input  wire logic      clk,
	input  wire logic      sys_rst,
	// Bus line levels.
	input  wire logic      scl_i,
	input  wire logic      sda_i,
	// Decoded line events.
	output scd_edge_t      edge_o
);

	scd_line_t q;
	scd_line_t d;

	// Previous line levels; idle bus is high, so reset to high avoids a false clock rise.
	always_comb begin
		d.scl = scl_i;
		d.sda = sda_i;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '{scl: 1'b1, sda: 1'b1};
		end else begin
			q <= d;
		end
	end

	// Data changes while the clock is high are control conditions, not data.
	always_comb begin
		edge_o.scl_rise = scl_i & ~q.scl;
		edge_o.scl_fall = ~scl_i & q.scl;
		edge_o.start    = scl_i & q.scl & q.sda & ~sda_i;
		edge_o.stop     = scl_i & q.scl & ~q.sda & sda_i;
		edge_o.sda      = sda_i;
	end

endmodule

// file: sim/scd_master_model.sv
// Bus master model that drives the two-wire port as the controlling microcontroller would.
`timescale 1ns/1ps
module scd_master_model #(
	parameter int HALF = 4
)
(
	// Clock.
	input  wire logic clk,
	// Resolved line levels.
	input  wire logic scl_w,
	input  wire logic sda_w,
	// Line releases, 1 lets the pull-up win.
	output logic      scl_m,
	output logic      sda_m
);
	int stretch_max;
	int stuck;
	// Both lines start released, so the bus is idle.
	initial begin
		scl_m = 1'b1;
		sda_m = 1'b1;
		stretch_max = 0;
		stuck = 0;
	end
	// Half a bus clock period.
	task automatic hp;
		repeat (HALF) @(negedge clk);
	endtask
	// Releases the clock and waits for the wire to rise; the device may hold it low for a long time.
	task automatic scl_up;
		int n;
		n = 0;
		scl_m = 1'b1;
		do begin
			@(negedge clk);
			n++;
		end while (scl_w !== 1'b1 && n < 3000);
		if (n >= 3000) stuck++;
		if (n > stretch_max) stretch_max = n;
		hp;
	endtask
	// One clock pulse; data moves half a period and a cycle after the fall so it never changes while the clock is high.
	task automatic bit_io(input logic b, output logic seen);
		@(negedge clk);
		sda_m = b;
		hp;
		scl_up;
		seen = sda_w;
		scl_m = 1'b0;
		hp;
	endtask
	// Start or repeated start: data falls while the clock is high.
	task automatic start;
		@(negedge clk);
		sda_m = 1'b1;
		hp;
		scl_up;
		sda_m = 1'b0;
		hp;
		scl_m = 1'b0;
		hp;
	endtask
	// Stop: data rises while the clock is high.
	task automatic stop;
		@(negedge clk);
		sda_m = 1'b0;
		hp;
		scl_up;
		sda_m = 1'b1;
		hp;
	endtask
	// Writes a byte high bit first and returns the acknowledge.
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	// Reads a byte; a missing acknowledge tells the device to stop sending.
	task automatic rd_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(~ack, s);
	endtask
endmodule

// file: sim/tb_top.sv
// Self-checking bench: the master model sends commands and the bench checks the decoded outputs.
`timescale 1ns/1ps
module tb_top import scd_pkg::*;;
	localparam logic [2:0] ID = 3'h5;  // Arbitrary value.
	logic        clk;
	logic        sys_rst;
	logic        hi_pin;
	logic        lo_pin;
	logic        dev_ready;
	logic [4:0]  dev_status;
	logic [15:0] cur_addr;
	logic [7:0]  rd_data;
	logic        scl_m;
	logic        sda_m;
	logic        scl_oe_n;
	logic        sda_oe_n;
	logic        cmd_stb;
	scd_op_t     cmd_op;
	logic        power_up;
	logic        reg_wr;
	scd_reg_t    reg_sel;
	logic [15:0] reg_data;
	logic        wr_stb;
	logic [7:0]  wr_data;
	logic        rd_req;
	logic        ack;
	logic [2:0]  ld;
	wire         scl_w;
	wire         sda_w;
	int          err_count;
	int          checks_done;
	int          cyc;
	int          n_cmd;
	int          n_reg;
	int          n_wr;
	int          n_rd;
	// Open-drain wires: either party pulling low wins over the pull-up.
	assign scl_w = scl_m & scl_oe_n;
	assign sda_w = sda_m & sda_oe_n;
	scd_master_model u_mst (.clk(clk), .scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m));
	scd_top #(.DEVICE_ID(ID)) u_dut (
		.CLK(clk), .SYS_RST(sys_rst), .SCL_I(scl_w), .SCL_O(), .SCL_OE_N(scl_oe_n),
		.SDA_I(sda_w), .SDA_O(), .SDA_OE_N(sda_oe_n), .ADDR_SELECT_HI_PIN(hi_pin),
		.ADDR_SELECT_LO_PIN(lo_pin), .DEV_READY(dev_ready), .DEV_STATUS(dev_status),
		.CUR_ADDR(cur_addr), .CMD_STB(cmd_stb), .CMD_OP(cmd_op), .POWER_UP(power_up),
		.REG_WR(reg_wr), .REG_SEL(reg_sel), .REG_DATA(reg_data), .WR_STB(wr_stb),
		.WR_DATA(wr_data), .RD_REQ(rd_req), .RD_DATA(rd_data));
	// Free-running 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Counts strobes, serves a fresh read byte after each fetch, and cuts a hang short.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cmd_stb === 1'b1) n_cmd <= n_cmd + 1;
		if (reg_wr === 1'b1) n_reg <= n_reg + 1;
		if (wr_stb === 1'b1) n_wr <= n_wr + 1;
		if (rd_req === 1'b1) n_rd <= n_rd + 1;
		if (rd_req === 1'b1) rd_data <= rd_data + 8'h01;
		if (cyc == 60000) begin
			err_count++;
			final_report;
		end
	end
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Strobe counters are cleared off the sampling edge.
	task automatic clr;
		@(negedge clk);
		n_cmd = 0;
		n_reg = 0;
		n_wr = 0;
		n_rd = 0;
	endtask
	task automatic send(input logic [7:0] d);
		u_mst.wr_byte(d, ack);
		chk("ack", {15'h0, ack}, 16'h1);
	endtask
	task automatic take(input logic a, input logic [7:0] exp);
		logic [7:0] d;
		u_mst.rd_byte(a, d);
		chk("read byte", {8'h0, d}, {8'h0, exp});
	endtask
	function automatic scd_op_t exp_op(input logic [3:0] c);
		case (c)
			4'h0: exp_op = SCD_OP_STOP;
			4'h5: exp_op = SCD_OP_PLAY;
			4'h2: exp_op = SCD_OP_RECORD;
			4'h7: exp_op = SCD_OP_CUE;
			4'hC: exp_op = SCD_OP_DREAD;
			4'h9: exp_op = SCD_OP_DWRITE;
			4'hA: exp_op = SCD_OP_ERASE;
			default: exp_op = SCD_OP_NOP;
		endcase
	endfunction
	// Top bit flags a real load, the low bits name the register.
	function automatic logic [2:0] exp_load(input logic [2:0] rg);
		case (rg)
			3'h1: exp_load = {1'b1, SCD_REG_ADDR};
			3'h2: exp_load = {1'b1, SCD_REG_CONFIG_REG_0};
			3'h3: exp_load = {1'b1, SCD_REG_CONFIG_REG_1};
			3'h5: exp_load = {1'b1, SCD_REG_CONFIG_REG_2};
			default: exp_load = 3'h0;
		endcase
	endfunction
	// Main sequence.
	initial begin
		sys_rst = 1'b1;
		hi_pin = 1'b1;
		lo_pin = 1'b0;
		dev_ready = 1'b1;
		dev_status = 5'h15;
		cur_addr = 16'hABCD;
		rd_data = 8'hA0;
		err_count = 0;
		checks_done = 0;
		cyc = 0;
		clr;
		repeat (6) @(negedge clk);
		chk("reset clock line", {15'h0, scl_oe_n}, 16'h1);
		chk("reset op", {13'h0, cmd_op}, {13'h0, SCD_OP_NOP});
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		// Foreign addresses must be ignored along with the byte after them.
		for (int i = 0; i < 3; i++) begin
			u_mst.start;
			u_mst.wr_byte(24'h808694 >> (16 - 8 * i), ack);
			chk("foreign ack", {15'h0, ack}, 16'h0);
			u_mst.wr_byte(8'hA8, ack);
			u_mst.stop;
		end
		chk("foreign strobes", n_cmd[15:0], 16'h0);
		chk("foreign op", {13'h0, cmd_op}, {13'h0, SCD_OP_NOP});
		$display("test foreign done");
		// Every select and function code, with the power bit toggling.
		for (int c = 0; c < 16; c++) begin
			u_mst.start;
			send(8'h84);
			send({c[0], c[3:0], 3'h0});
			u_mst.stop;
			chk("op", {13'h0, cmd_op}, {13'h0, exp_op(c[3:0])});
			chk("power", {15'h0, power_up}, {15'h0, c[0]});
		end
		$display("test opcodes done");
		// Every load code with the stop function.
		for (int r = 0; r < 8; r++) begin
			clr;
			ld = exp_load(r[2:0]);
			u_mst.start;
			send(8'h84);
			send({5'h10, r[2:0]});
			u_mst.wr_byte({5'h02, r[2:0]}, ack);
			u_mst.wr_byte(8'hC3, ack);
			u_mst.stop;
			chk("loads", n_reg[15:0], {15'h0, ld[2]});
			chk("op strobes", n_cmd[15:0], 16'h1);
			if (ld[2]) begin
				chk("load sel", {14'h0, reg_sel}, {14'h0, ld[1:0]});
				chk("load data", reg_data, {5'h02, r[2:0], 8'hC3});
				chk("load op", {13'h0, cmd_op}, {13'h0, SCD_OP_STOP});
			end
		end
		$display("test loads done");
		// Digital write at the other pin address.
		hi_pin = 1'b0;
		lo_pin = 1'b1;
		clr;
		u_mst.start;
		send(8'h82);
		send(8'hC8);
		send(8'h5A);
		send(8'h3C);
		u_mst.stop;
		chk("write bytes", n_wr[15:0], 16'h2);
		chk("write data", {8'h0, wr_data}, 16'h003C);
		$display("test write done");
		// Address then read in one transfer, with the core busy at first.
		clr;
		dev_ready = 1'b0;
		fork
			begin
				repeat (400) @(negedge clk);
				dev_ready = 1'b1;
			end
		join_none
		u_mst.start;
		send(8'h82);
		send(8'hE1);
		// The hold after the address acknowledge only shows while the next byte's first bit is clocked.
		chk("stretch", {15'h0, u_mst.stretch_max > 150}, 16'h1);
		send(8'h00);
		send(8'h20);
		u_mst.start;
		send(8'h83);
		take(1'b1, 8'hA0);
		take(1'b1, 8'hA1);
		take(1'b0, 8'hA2);
		u_mst.stop;
		chk("fetches", n_rd[15:0], 16'h3);
		chk("address", reg_data, 16'h0020);
		chk("read op", {13'h0, cmd_op}, {13'h0, SCD_OP_DREAD});
		$display("test read done");
		// Status read: no command byte before the direction change.
		clr;
		u_mst.start;
		send(8'h82);
		u_mst.start;
		send(8'h83);
		take(1'b1, {dev_status, ID});
		take(1'b1, 8'hAB);
		take(1'b1, 8'hC0);
		take(1'b0, 8'hFF);
		u_mst.stop;
		chk("status fetches", n_rd[15:0], 16'h0);
		chk("clock stuck", u_mst.stuck[15:0], 16'h0);
		$display("test status done");
		final_report;
	end
endmodule
